//--- tb/rftx_fifo_model.sv
/* Show-ahead transmit FIFO model feeding the burst sequencer.
   Assumes the bench fills it through push before a trigger. */
`timescale 1ns/100ps
`default_nettype none
module rftx_fifo_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic fifo_pop,
    output logic [7:0] fifo_data,
    output logic fifo_valid
);
    logic [7:0] q[$];
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask : push
    task automatic flush;
        q.delete();
    endtask : flush
    // Empty: data toggles so a stale byte is never mistaken for a fresh one
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_valid <= 1'b0;
            fifo_data <= 8'h5a;
        end else begin
            if (fifo_pop === 1'b1 && q.size() > 0) begin
                void'(q.pop_front());
            end
            fifo_valid <= (q.size() > 0);
            fifo_data <= (q.size() > 0) ? q[0] : ~fifo_data;
        end
    end
endmodule : rftx_fifo_model
`default_nettype wire

//--- tb/rftx_op_ctrl_sva.sv
/* Port checker for rftx_op_ctrl.
   Assumes ce is held high and one request at a time. */
`timescale 1ns/100ps
`default_nettype none
module rftx_op_ctrl_sva
    import rftx_pkg::*;
#(
    parameter int BIT_CYCLES = rftx_pkg::DEF_BIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [rftx_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [rftx_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [rftx_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] fifo_data,
    input wire logic fifo_valid,
    input wire logic fifo_pop,
    input wire logic synth_enable,
    input wire logic tx_enable,
    input wire logic pa_enable,
    input wire logic freq_high,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_ask;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_oper_wr;
        avs_write && !avs_waitrequest && avs_address == OFS_OPER;
    endsequence
    a_one_wait: assert property (s_ask |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("wait state not exactly one cycle");
    a_unused_zero: assert property (s_ask ##0 (avs_read && avs_address == OFS_OPER) |=>
        avs_readdata[31:6] == '0 && avs_readdata[3:1] == '0) else $error("unused bits not zero");
    a_fsk_pa_on: assert property (freq_high |-> pa_enable)
        else $error("frequency steered with amplifier off");
    a_tx_needs_synth: assert property (tx_enable |-> synth_enable)
        else $error("transmitter on without synthesizer");
    a_pop_valid: assert property (fifo_pop |-> $past(fifo_valid) && synth_enable && tx_enable)
        else $error("pop without valid byte or while idle");
    a_pop_pulse: assert property (fifo_pop |=> !fifo_pop)
        else $error("pop longer than one cycle");
    a_trig_start: assert property (s_oper_wr ##0 (avs_writedata[0] && !avs_writedata[4] && !synth_enable)
        |-> ##[1:2] synth_enable) else $error("trigger did not start burst");
    a_abort_stop: assert property (s_oper_wr ##0 (!avs_writedata[0] && !avs_writedata[4])
        |-> ##[1:3] !tx_enable) else $error("abort did not stop transmitter");
    a_done_idle: assert property ($fell(synth_enable) |-> !tx_enable && !fifo_pop)
        else $error("transmitter left on at standby");
    a_reset_quiet: assert property ($rose(arst_n) |-> avs_waitrequest && !synth_enable
        && !tx_enable && !pa_enable && !freq_high && !irq) else $error("outputs not quiet after reset");
endmodule : rftx_op_ctrl_sva
bind rftx_op_ctrl rftx_op_ctrl_sva #(.BIT_CYCLES(BIT_CYCLES)) rftx_op_ctrl_sva_inst (
    .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_pop(fifo_pop), .synth_enable(synth_enable), .tx_enable(tx_enable),
    .pa_enable(pa_enable), .freq_high(freq_high), .irq(irq));
`default_nettype wire

//--- tb/rftx_op_ctrl_tb_top.sv
/* Self-checking bench for rftx_op_ctrl: register bus, direct and burst paths.
   Assumes one clock, ce held high, BIT_CYCLES shortened to 4. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module rftx_op_ctrl_tb_top;
    import rftx_pkg::*;
    localparam int BC = 4;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [2:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, fifo_pop, fifo_valid, synth_enable, tx_enable, pa_enable, freq_high, irq;
    logic [7:0] fifo_data;
    logic [31:0] seed = 32'h0000_50fb;
    int n_mismatch = 0, compares = 0, cyc = 0, n_pop = 0;
    always #2.5 core_clk = ~core_clk;
    rftx_op_ctrl #(.BIT_CYCLES(BC)) rftx_op_ctrl_inst (.core_clk(core_clk), .arst_n(arst_n), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fifo_data(fifo_data), .fifo_valid(fifo_valid), .fifo_pop(fifo_pop), .synth_enable(synth_enable),
        .tx_enable(tx_enable), .pa_enable(pa_enable), .freq_high(freq_high), .irq(irq));
    rftx_fifo_model rftx_fifo_model_inst (.core_clk(core_clk), .arst_n(arst_n), .fifo_pop(fifo_pop),
        .fifo_data(fifo_data), .fifo_valid(fifo_valid));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task stop_test;
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (fifo_pop === 1'b1) n_pop++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // Request held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdr(input logic [2:0] a);
        bus(1'b0, a, '0);
    endtask : rdr
    // Samples mid-bit, MSB first, timed from the pop of the first byte
    task automatic capture(input logic fsk, input logic [7:0] b);
        do @(posedge core_clk); while (fifo_pop !== 1'b1);
        for (int i = 7; i >= 0; i--) begin
            repeat (i == 7 ? 3 : 4) @(posedge core_clk);
            `CHK("burst pa", fsk ? 1'b1 : b[i], pa_enable)
            `CHK("burst freq", fsk ? b[i] : 1'b0, freq_high)
        end
    endtask : capture
    task automatic burst(input int n, input logic fsk, input logic [7:0] b0);
        n_pop = 0;
        for (int i = 0; i < n; i++) rftx_fifo_model_inst.push(b0 + 8'(i));
        fork
            if (n > 0) capture(fsk, b0);
            begin
                wr(OFS_OPER, fsk ? 32'h0000_0021 : 32'h0000_0001);
                rdr(OFS_OPER);
                if (n > 0) `CHK("trigger set", 1'b1, rd[0])
                if (n > 0) begin
                    rdr(OFS_STATUS);
                    `CHK("busy status", 32'h0000_0003, rd)
                end
                while (rd[0] !== 1'b0) rdr(OFS_OPER);
                `CHK("synth off", 1'b0, synth_enable)
                `CHK("tx off", 1'b0, tx_enable)
            end
        join
        `CHK("bytes sent", n, n_pop)
    endtask : burst
    task automatic ack(input logic on);
        `CHK("irq level", on, irq)
        rdr(OFS_IRQ_STAT);
        `CHK("done status", 32'h0000_0001, rd)
        repeat (2) @(posedge core_clk);
        `CHK("irq cleared", 1'b0, irq)
    endtask : ack
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 7; i++) begin
            rdr(3'(i));
            `CHK("reset read", 32'h0000_0000, rd)
        end
        $display("test reset done");
        wr(OFS_OPER, 32'h0000_00fe);
        rdr(OFS_OPER);
        `CHK("oper readback", 32'h0000_0030, rd)
        wr(OFS_OPER, 32'h0000_0011);
        rdr(OFS_OPER);
        `CHK("trigger in direct", 32'h0000_0010, rd)
        wr(OFS_RF_EN, 32'h0000_0001);
        `CHK("synth first", 2'b10, {synth_enable, tx_enable})
        wr(OFS_RF_EN, 32'h0000_0003);
        `CHK("tx second", 2'b11, {synth_enable, tx_enable})
        for (int m = 0; m < 2; m++) begin
            wr(OFS_OPER, m ? 32'h0000_0030 : 32'h0000_0010);
            repeat (6) begin
                seed = lfsr(seed);
                wr(OFS_DIRECT, 32'(seed[0]));
                repeat (2) @(posedge core_clk);
                `CHK("direct pa", m ? 1'b1 : seed[0], pa_enable)
                `CHK("direct freq", m ? seed[0] : 1'b0, freq_high)
            end
        end
        wr(OFS_RF_EN, '0);
        wr(OFS_OPER, '0);
        $display("test direct done");
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        repeat (6) begin
            seed = lfsr(seed);
            burst(1, seed[8], seed[7:0]);
            ack(1'b1);
        end
        burst(3, seed[9], seed[15:8]);
        ack(1'b1);
        $display("test burst done");
        wr(OFS_IRQ_MASK, '0);
        burst(0, 1'b0, 8'h00);
        `CHK("masked irq", 1'b0, irq)
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        ack(1'b1);
        $display("test empty burst done");
        for (int i = 0; i < 3; i++) rftx_fifo_model_inst.push(8'h96);
        n_pop = 0;
        wr(OFS_OPER, 32'h0000_0001);
        repeat (20) @(posedge core_clk);
        wr(OFS_OPER, '0);
        rdr(OFS_OPER);
        `CHK("abort trigger", 32'h0000_0000, rd)
        `CHK("abort tx", 1'b0, tx_enable)
        `CHK("abort bytes", 1'b1, n_pop < 3)
        rdr(OFS_IRQ_STAT);
        `CHK("abort no irq", 32'h0000_0000, rd)
        rftx_fifo_model_inst.flush();
        $display("test abort done");
        stop_test();
    end
endmodule : rftx_op_ctrl_tb_top
`default_nettype wire

//--- verilog/rftx_bit_if.sv
/*
 * Internal carrier between the control core, the bit serializer and the
 * modulation stage.
 * Assumes all parties run on one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface rftx_bit_if;
    logic byte_load;
    logic [7:0] byte_data;
    logic stop;
    logic ser_bit;
    logic ser_busy;
    logic byte_done;
    logic fsk;
    logic src_bit;
    logic active;
    logic pa_en;
    logic freq_hi;

    modport ctl(output byte_load, byte_data, stop, fsk, src_bit, active,
                input ser_bit, ser_busy, byte_done, pa_en, freq_hi);
    modport ser(input byte_load, byte_data, stop, output ser_bit, ser_busy, byte_done);
    modport modu(input fsk, src_bit, active, output pa_en, freq_hi);
endinterface : rftx_bit_if
`default_nettype wire

//--- verilog/rftx_modulator.sv
/*
 * Turns the current transmit bit into amplifier enable and frequency select.
 * Assumes the bit source and mode are chosen by the control core.
 */
`timescale 1ns/100ps
`default_nettype none
module rftx_modulator (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    rftx_bit_if.modu bus
);
    import rftx_pkg::*;

    typedef struct packed {
        logic pa_en;
        logic freq_hi;
    } rftx_mod_s_t;

    rftx_mod_s_t q;
    rftx_mod_s_t n;

    always_comb begin
        n = q;
        if (!bus.active) begin
            n.pa_en = 1'b0;
            n.freq_hi = 1'b0;
        end else if (bus.fsk) begin
            n.pa_en = 1'b1;
            n.freq_hi = bus.src_bit;
        end else begin
            n.pa_en = bus.src_bit;
            n.freq_hi = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= n;
        end
    end

    assign bus.pa_en = q.pa_en;
    assign bus.freq_hi = q.freq_hi;
endmodule : rftx_modulator
`default_nettype wire

//--- verilog/rftx_op_ctrl.sv
/*
 * Operation control of the RF transmitter: register file on Avalon-MM,
 * burst sequencer fed from an external show-ahead FIFO, direct mode path,
 * and the burst done interrupt.
 * Assumes the FIFO presents its head byte with fifo_valid and drops it on
 * a one-cycle fifo_pop; the analogue side acts on the enables it is given.
 */
`timescale 1ns/100ps
`default_nettype none
module rftx_op_ctrl #(
    parameter int BIT_CYCLES = rftx_pkg::DEF_BIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [rftx_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [rftx_pkg::DATA_W-1:0] avs_writedata,
    output logic [rftx_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] fifo_data,
    input wire logic fifo_valid,
    output logic fifo_pop,
    output logic synth_enable,
    output logic tx_enable,
    output logic pa_enable,
    output logic freq_high,
    output logic irq
);
    import rftx_pkg::*;

    typedef struct packed {
        logic freq_shift_select;
        logic direct_select;
        logic send_trigger;
        logic direct_tx_bit;
        logic synth_on;
        logic tx_on;
        logic done_stat;
        logic done_mask;
        logic [DATA_W-1:0] rdata;
        logic wreq;
        logic irq;
        logic pop;
        logic synth_en;
        logic tx_en;
        logic load;
        logic stop;
        logic [7:0] byte_q;
        rftx_state_t st;
    } rftx_ctl_s_t;

    rftx_ctl_s_t q;
    rftx_ctl_s_t n;

    rftx_bit_if bit_if();

    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic lane0;

    rftx_serializer #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_ser (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .ce(ce),
        .bus(bit_if.ser)
    );

    rftx_modulator u_mod (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .ce(ce),
        .bus(bit_if.modu)
    );

    // Request taken at the edge where waitrequest is sampled low
    assign acc = (avs_read || avs_write) && !q.wreq;
    assign wr_acc = acc && avs_write;
    assign rd_acc = acc && avs_read;
    assign lane0 = avs_byteenable[0];

    // Byte, load and stop for the serializer; bit source and activity for the modulation stage
    assign bit_if.byte_load = q.load;
    assign bit_if.byte_data = q.byte_q;
    assign bit_if.stop = q.stop;
    assign bit_if.fsk = q.freq_shift_select;
    assign bit_if.src_bit = q.direct_select ? q.direct_tx_bit : bit_if.ser_bit;
    assign bit_if.active = q.direct_select ? (q.synth_on && q.tx_on) : bit_if.ser_busy;

    always_comb begin
        n = q;
        n.pop = 1'b0;
        n.load = 1'b0;
        n.stop = 1'b0;

        // One wait cycle, then a single cycle with waitrequest low
        if ((avs_read || avs_write) && q.wreq) begin
            n.wreq = 1'b0;
        end else begin
            n.wreq = 1'b1;
        end

        // Read image captured one cycle ahead of the accepting edge
        if (avs_read && q.wreq) begin
            n.rdata = READ_ZERO;
            if (rftx_hit(avs_address, OFS_OPER)) begin
                n.rdata[OPER_FSK_BIT] = q.freq_shift_select;
                n.rdata[OPER_DIRECT_BIT] = q.direct_select;
                n.rdata[OPER_STROBE_BIT] = q.send_trigger;
            end else if (rftx_hit(avs_address, OFS_DIRECT)) begin
                n.rdata[DIRECT_TX_BIT] = q.direct_tx_bit;
            end else if (rftx_hit(avs_address, OFS_RF_EN)) begin
                n.rdata[RF_EN_SYNTH_BIT] = q.synth_on;
                n.rdata[RF_EN_TX_BIT] = q.tx_on;
            end else if (rftx_hit(avs_address, OFS_IRQ_STAT)) begin
                n.rdata[IRQ_DONE_BIT] = q.done_stat;
            end else if (rftx_hit(avs_address, OFS_IRQ_MASK)) begin
                n.rdata[IRQ_DONE_BIT] = q.done_mask;
            end else if (rftx_hit(avs_address, OFS_STATUS)) begin
                n.rdata[STATUS_BUSY_BIT] = (q.st != ST_IDLE);
                n.rdata[STATUS_SENDING_BIT] = bit_if.ser_busy;
            end
        end

        // Read clears only what the reader has seen
        if (rd_acc && rftx_hit(avs_address, OFS_IRQ_STAT) && q.rdata[IRQ_DONE_BIT]) begin
            n.done_stat = 1'b0;
        end

        // Burst sequencer
        case (q.st)
            ST_IDLE: begin
                if (q.send_trigger && !q.direct_select) begin
                    n.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (fifo_valid) begin
                    n.pop = 1'b1;
                    n.load = 1'b1;
                    n.byte_q = fifo_data;
                    n.st = ST_SHIFT;
                end else begin
                    n.st = ST_DONE;
                end
            end
            ST_SHIFT: begin
                if (bit_if.byte_done) begin
                    n.st = ST_LOAD;
                end
            end
            ST_DONE: begin
                n.send_trigger = 1'b0;
                n.done_stat = 1'b1;
                n.st = ST_IDLE;
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase

        // Register writes
        if (wr_acc && lane0) begin
            if (rftx_hit(avs_address, OFS_OPER)) begin
                // Mode bits held while a burst runs; software keeps off them anyway
                if (q.st == ST_IDLE && !q.send_trigger) begin
                    n.freq_shift_select = avs_writedata[OPER_FSK_BIT];
                    n.direct_select = avs_writedata[OPER_DIRECT_BIT];
                    if (avs_writedata[OPER_STROBE_BIT] && !avs_writedata[OPER_DIRECT_BIT]) begin
                        n.send_trigger = 1'b1;
                    end
                end else if (!avs_writedata[OPER_STROBE_BIT] && q.send_trigger && q.st != ST_DONE) begin
                    n.send_trigger = 1'b0;
                    n.stop = 1'b1;
                    n.pop = 1'b0;
                    n.load = 1'b0;
                    n.st = ST_IDLE;
                end
            end else if (rftx_hit(avs_address, OFS_DIRECT)) begin
                n.direct_tx_bit = avs_writedata[DIRECT_TX_BIT];
            end else if (rftx_hit(avs_address, OFS_RF_EN)) begin
                n.synth_on = avs_writedata[RF_EN_SYNTH_BIT];
                n.tx_on = avs_writedata[RF_EN_TX_BIT];
            end else if (rftx_hit(avs_address, OFS_IRQ_MASK)) begin
                n.done_mask = avs_writedata[IRQ_DONE_BIT];
            end
        end

        // Enables: software sequenced in direct mode, sequencer driven in burst
        if (n.direct_select) begin
            n.synth_en = n.synth_on;
            n.tx_en = n.synth_on && n.tx_on;
        end else begin
            n.synth_en = (n.st != ST_IDLE);
            n.tx_en = (n.st == ST_SHIFT) || (n.st == ST_LOAD && q.st == ST_SHIFT);
        end

        n.irq = n.done_stat && n.done_mask;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.freq_shift_select <= OPER_RESET[OPER_FSK_BIT];
            q.direct_select <= OPER_RESET[OPER_DIRECT_BIT];
            q.send_trigger <= OPER_RESET[OPER_STROBE_BIT];
            q.direct_tx_bit <= DIRECT_RESET[DIRECT_TX_BIT];
            q.synth_on <= RF_EN_RESET[RF_EN_SYNTH_BIT];
            q.tx_on <= RF_EN_RESET[RF_EN_TX_BIT];
            q.done_mask <= IRQ_MASK_RESET[IRQ_DONE_BIT];
            q.wreq <= 1'b1;
            q.st <= ST_IDLE;
        end else if (ce) begin
            q <= n;
        end
    end

    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wreq;
    assign fifo_pop = q.pop;
    assign synth_enable = q.synth_en;
    assign tx_enable = q.tx_en;
    assign pa_enable = bit_if.pa_en;
    assign freq_high = bit_if.freq_hi;
    assign irq = q.irq;
endmodule : rftx_op_ctrl
`default_nettype wire

//--- verilog/rftx_pkg.sv
/*
 * Shared constants, register map, field positions and state encodings of the
 * RF transmitter operation control block.
 * Assumes a word-addressed Avalon-MM slave port with 32-bit data and one clock.
 */
// Summary of operation
// - Bits 7, 6, 3, 2 and 1 of the operation control register always read back as zero.
// - With the modulation select bit at 0 the amplifier enable follows the transmit bit directly (OOK).
// - With the modulation select bit (bit 5) at 1 the amplifier stays on and the bit steers the frequency (FSK); in burst the amplifier is off between bytes.
// - With the direct select bit at 0 the payload comes from the transmit FIFO under a state machine.
// - Once the FIFO payload has been sent in burst operation the transmitter drops back to standby.
// - With the direct select bit at 1 the transmitted bit is the software-written direct data bit.
// - Writing 1 to the send trigger bit (bit 0) with the direct select bit at 0 starts a burst packet transmission.
// - Hardware clears the send trigger bit once the whole packet has gone out.
// - Completion raises the burst done interrupt in the same cycle that the trigger bit clears.
// - Writing 0 to the trigger bit during a burst aborts it and the block stops sending.
package rftx_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 32;

    // Word indices on the bus
    localparam logic [2:0] OFS_OPER = 3'h0;
    localparam logic [2:0] OFS_DIRECT = 3'h1;
    localparam logic [2:0] OFS_RF_EN = 3'h2;
    localparam logic [2:0] OFS_IRQ_STAT = 3'h3;
    localparam logic [2:0] OFS_IRQ_MASK = 3'h4;
    localparam logic [2:0] OFS_STATUS = 3'h5;

    // Field positions
    localparam int OPER_STROBE_BIT = 0;
    localparam int OPER_DIRECT_BIT = 4;
    localparam int OPER_FSK_BIT = 5;
    localparam int DIRECT_TX_BIT = 0;
    localparam int RF_EN_SYNTH_BIT = 0;
    localparam int RF_EN_TX_BIT = 1;
    localparam int IRQ_DONE_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_SENDING_BIT = 1;

    // Values after reset
    localparam logic [7:0] OPER_RESET = 8'h00;
    localparam logic [7:0] DIRECT_RESET = 8'h00;
    localparam logic [7:0] RF_EN_RESET = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Cycles per transmitted bit
    localparam int DEF_BIT_CYCLES = 200;
    localparam int BIT_CNT_W = 16;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_DONE = 4'b1000
    } rftx_state_t;

    function automatic logic rftx_hit(input logic [2:0] addr, input logic [2:0] ofs);
        rftx_hit = (addr == ofs);
    endfunction : rftx_hit

endpackage : rftx_pkg

//--- verilog/rftx_serializer.sv
/*
 * Shifts one payload byte out MSB first, one bit per BIT_CYCLES clocks.
 * Assumes a load pulse only while idle; stop cancels at once.
 */
`timescale 1ns/100ps
`default_nettype none
module rftx_serializer #(
    parameter int BIT_CYCLES = rftx_pkg::DEF_BIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    rftx_bit_if.ser bus
);
    import rftx_pkg::*;

    typedef struct packed {
        logic [7:0] shreg;
        logic [BIT_CNT_W-1:0] cnt;
        logic [2:0] bitn;
        logic busy;
        logic done;
    } rftx_ser_s_t;

    rftx_ser_s_t q;
    rftx_ser_s_t n;

    always_comb begin
        n = q;
        n.done = 1'b0;
        if (bus.stop) begin
            n.busy = 1'b0;
        end else if (bus.byte_load && !q.busy) begin
            n.shreg = bus.byte_data;
            n.cnt = '0;
            n.bitn = BYTE_LAST_BIT;
            n.busy = 1'b1;
        end else if (q.busy) begin
            if (q.cnt == BIT_CNT_W'(BIT_CYCLES - 1)) begin
                n.cnt = '0;
                if (q.bitn == 3'h0) begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end else begin
                    n.shreg = {q.shreg[6:0], 1'b0};
                    n.bitn = q.bitn - 3'h1;
                end
            end else begin
                n.cnt = q.cnt + BIT_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= n;
        end
    end

    assign bus.ser_bit = q.shreg[7];
    assign bus.ser_busy = q.busy;
    assign bus.byte_done = q.done;
endmodule : rftx_serializer
`default_nettype wire
